// ==== core/path_alarm_pkg.sv ====
// Package with register offsets, field positions and codes for the path alarm stage
package path_alarm_pkg;
   // Register offsets (low byte of the channel register window)
   localparam logic [7:0] PARITY_MASK_OFFSET  = 8'h97;
   localparam logic [7:0] TX_CONTROL0_OFFSET  = 8'h83;
   localparam logic [7:0] DEFECT_CTRL2_OFFSET = 8'hC9;
   // Reset values
   localparam logic [7:0] PARITY_MASK_RESET   = 8'h00;
   localparam logic [7:0] TX_CONTROL0_RESET   = 8'h00;
   localparam logic [7:0] DEFECT_CTRL2_RESET  = 8'h00;
   // Control byte 0 fields
   localparam int         AIS_ENABLE_BIT      = 0;
   localparam int         RDI_SEL_LSB         = 3;
   localparam logic [7:0] CONTROL0_RO_MASK    = 8'h02;
   // Defect control byte 2 fields
   localparam int         PLM_ENABLE_BIT      = 0;
   localparam int         PLM_CODE_LSB        = 1;
   localparam int         LCD_ENABLE_BIT      = 4;
   localparam int         LCD_CODE_LSB        = 5;
   // Remote defect source select encodings
   localparam logic [1:0] RDI_SRC_AUTO        = 2'h0;
   localparam logic [1:0] RDI_SRC_SOFTWARE    = 2'h1;
   // Position of the remote defect bits inside the path status byte
   localparam int         G1_RDI_LSB          = 1;
   localparam logic [7:0] ALL_ONES            = 8'hFF;
   localparam logic [2:0] RDI_CLEAR_CODE      = 3'h0;
   localparam logic [7:0] BYTE_ZERO           = 8'h00;
endpackage

// ==== core/path_alarm_b3_error_insert.sv ====
// Transmit path alarm stage: parity error insertion, path AIS and RDI-P sourcing
`timescale 1ns/1ps
module path_alarm_b3_error_insert
   import path_alarm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Upstream byte stream from the payload mapper
   input  wire logic [7:0] data_i,
   input  wire logic       spe_i,
   input  wire logic       spe_start_i,
   input  wire logic       parity_pos_i,
   input  wire logic       status_pos_i,
   input  wire logic       pointer_pos_i,
   // Receive-side defects and external overhead input
   input  wire logic       plm_defect_i,
   input  wire logic       lcd_defect_i,
   input  wire logic [2:0] external_path_overhead_input,
   input  wire logic [2:0] soft_rdi_code_i,
   // Downstream byte stream to the overhead processor
   output logic      [7:0] data_o,
   output logic            payload_blocked_o
);

   // Register state
   logic [7:0] mask_reg,   mask_next;    // Parity error mask
   logic [7:0] ctrl0_reg,  ctrl0_next;   // Path control byte 0
   logic [7:0] ctrl2_reg,  ctrl2_next;   // Defect control byte 2
   logic [7:0] rdata_reg,  rdata_next;   // Read data holding register
   // Datapath state
   logic [7:0] bip_reg,    bip_next;     // Running parity of current SPE
   logic [7:0] sent_reg,   sent_next;    // Parity of previous SPE
   logic [7:0] dout_reg,   dout_next;    // Outbound byte
   logic       block_reg,  block_next;   // Payload suppressed flag
   // Decoded controls
   logic       ais_en;
   logic [1:0] rdi_sel;
   logic [2:0] rdi_code;

   // Register read decode, used by read path
   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] m,
                                           input logic [7:0] c0, input logic [7:0] c2);
      case (a)
         PARITY_MASK_OFFSET:  read_mux = m;
         TX_CONTROL0_OFFSET:  read_mux = c0;
         DEFECT_CTRL2_OFFSET: read_mux = c2;
         default:             read_mux = BYTE_ZERO;   // Unmapped reads as zero
      endcase
   endfunction

   // Register file next-state logic
   always_comb begin
      mask_next  = mask_reg;
      ctrl0_next = ctrl0_reg;
      ctrl2_next = ctrl2_reg;
      rdata_next = rdata_reg;
      if (reg_wr_i) begin
         case (reg_addr_i)
            PARITY_MASK_OFFSET:  mask_next  = reg_wdata_i;
            TX_CONTROL0_OFFSET:  ctrl0_next = reg_wdata_i & ~CONTROL0_RO_MASK;
            DEFECT_CTRL2_OFFSET: ctrl2_next = reg_wdata_i;
            default: ;                                         // Writes elsewhere ignored
         endcase
      end
      if (reg_rd_i) begin
         rdata_next = read_mux(reg_addr_i, mask_reg, ctrl0_reg, ctrl2_reg);
      end
   end

   // Register file flops
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_reg  <= PARITY_MASK_RESET;
         ctrl0_reg <= TX_CONTROL0_RESET;
         ctrl2_reg <= DEFECT_CTRL2_RESET;
         rdata_reg <= BYTE_ZERO;
      end else begin
         mask_reg  <= mask_next;
         ctrl0_reg <= ctrl0_next;
         ctrl2_reg <= ctrl2_next;
         rdata_reg <= rdata_next;
      end
   end

   assign ais_en  = ctrl0_reg[AIS_ENABLE_BIT];
   assign rdi_sel = ctrl0_reg[RDI_SEL_LSB +: 2];

   // Remote defect code selection; mismatch outranks delineation when both are up
   always_comb begin
      rdi_code = RDI_CLEAR_CODE;
      case (rdi_sel)
         RDI_SRC_AUTO: begin
            if (plm_defect_i && ctrl2_reg[PLM_ENABLE_BIT]) begin
               rdi_code = ctrl2_reg[PLM_CODE_LSB +: 3];
            end else if (lcd_defect_i && ctrl2_reg[LCD_ENABLE_BIT]) begin
               rdi_code = ctrl2_reg[LCD_CODE_LSB +: 3];
            end
         end
         RDI_SRC_SOFTWARE: rdi_code = soft_rdi_code_i;
         default:          rdi_code = external_path_overhead_input;
      endcase
   end

   // Datapath next state: parity, error mask, AIS and status byte insertion
   always_comb begin
      bip_next   = bip_reg;
      sent_next  = sent_reg;
      dout_next  = data_i;
      block_next = ais_en;
      if (parity_pos_i) begin
         dout_next = sent_reg ^ mask_reg;
      end else if (status_pos_i) begin
         dout_next = data_i;
         dout_next[G1_RDI_LSB +: 3] = rdi_code;
      end
      if (ais_en && (spe_i || pointer_pos_i)) begin
         dout_next = ALL_ONES;
      end
      // Parity covers the bytes actually sent in the SPE
      if (spe_i) begin
         if (spe_start_i) begin
            // First byte opens the new SPE, so the old sum closes without it
            sent_next = bip_reg;
            bip_next  = dout_next;
         end else begin
            bip_next  = bip_reg ^ dout_next;
         end
      end
   end

   // Datapath flops
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bip_reg   <= BYTE_ZERO;
         sent_reg  <= BYTE_ZERO;
         dout_reg  <= BYTE_ZERO;
         block_reg <= 1'b0;
      end else begin
         bip_reg   <= bip_next;
         sent_reg  <= sent_next;
         dout_reg  <= dout_next;
         block_reg <= block_next;
      end
   end

   assign data_o            = dout_reg;
   assign reg_rdata_o       = rdata_reg;
   assign payload_blocked_o = block_reg;

   // Checks
   property p_parity_mask;
      @(posedge clk_i) disable iff (!nrst_i)
      (parity_pos_i && !ais_en) |=> (data_o == ($past(sent_reg) ^ $past(mask_reg)));
   endproperty
   a_parity_mask: assert property (p_parity_mask) else $error("parity byte not masked");

   property p_mask_persist;
      @(posedge clk_i) disable iff (!nrst_i)
      (parity_pos_i && !ais_en && mask_reg != BYTE_ZERO) |=> (data_o != $past(sent_reg));
   endproperty
   a_mask_persist: assert property (p_mask_persist) else $error("mask not applied");

   property p_parity_next;
      @(posedge clk_i) disable iff (!nrst_i)
      (spe_i && spe_start_i) |=> ((sent_reg == $past(bip_reg)) && (bip_reg == data_o));
   endproperty
   a_parity_next: assert property (p_parity_next) else $error("parity not carried");

   property p_ais_spe;
      @(posedge clk_i) disable iff (!nrst_i)
      (ais_en && spe_i) |=> (data_o == ALL_ONES);
   endproperty
   a_ais_spe: assert property (p_ais_spe) else $error("AIS SPE byte not ones");

   property p_ais_ptr;
      @(posedge clk_i) disable iff (!nrst_i)
      (ais_en && pointer_pos_i) |=> (data_o == ALL_ONES);
   endproperty
   a_ais_ptr: assert property (p_ais_ptr) else $error("AIS pointer not ones");

   property p_ais_block;
      @(posedge clk_i) disable iff (!nrst_i)
      ais_en |=> payload_blocked_o;
   endproperty
   a_ais_block: assert property (p_ais_block) else $error("payload not blocked");

   property p_plm_code;
      @(posedge clk_i) disable iff (!nrst_i)
      (status_pos_i && !ais_en && rdi_sel == RDI_SRC_AUTO && plm_defect_i
       && ctrl2_reg[PLM_ENABLE_BIT])
      |=> (data_o[G1_RDI_LSB +: 3] == $past(ctrl2_reg[PLM_CODE_LSB +: 3]));
   endproperty
   a_plm_code: assert property (p_plm_code) else $error("mismatch code missing");

   property p_plm_gate;
      @(posedge clk_i) disable iff (!nrst_i)
      (status_pos_i && !ais_en && rdi_sel == RDI_SRC_AUTO && !ctrl2_reg[PLM_ENABLE_BIT]
       && !(lcd_defect_i && ctrl2_reg[LCD_ENABLE_BIT]))
      |=> (data_o[G1_RDI_LSB +: 3] == RDI_CLEAR_CODE);
   endproperty
   a_plm_gate: assert property (p_plm_gate) else $error("disabled mismatch altered RDI");

   property p_ext_src;
      @(posedge clk_i) disable iff (!nrst_i)
      (status_pos_i && !ais_en && rdi_sel == 2'h2)
      |=> (data_o[G1_RDI_LSB +: 3] == $past(external_path_overhead_input));
   endproperty
   a_ext_src: assert property (p_ext_src) else $error("external RDI not used");

endmodule

// ==== verification/remote_path_model.sv ====
// Remote path terminal model that rechecks the carried parity byte
`timescale 1ns/1ps
module remote_path_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Outbound byte and the markers of the input byte behind it
   input  wire logic [7:0] data_i,
   input  wire logic [2:0] mark_i,
   // Carried parity XOR recomputed parity
   output logic      [7:0] b3_diff_o
);
   logic [2:0] mark_reg; // SPE, SPE start, parity position
   logic [7:0] acc_reg;  // Running parity
   logic [7:0] done_reg; // Parity of the last whole SPE
   // Markers lag one cycle so they meet the registered byte
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {mark_reg, acc_reg, done_reg, b3_diff_o} <= 27'h0;
      end else begin
         mark_reg <= mark_i;
         if (mark_reg[1]) begin
            done_reg <= acc_reg;
            acc_reg  <= data_i;
         end else if (mark_reg[2]) begin
            acc_reg <= acc_reg ^ data_i;
         end
         if (mark_reg[0]) begin
            b3_diff_o <= data_i ^ done_reg;
         end
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Random stream bench for the path alarm stage
`timescale 1ns/1ps
module tb_top;
   import path_alarm_pkg::*;
   localparam int FR = 12; // Bytes per short test frame
   logic clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, spe_i = 0, spe_start_i = 0;
   logic parity_pos_i = 0, status_pos_i = 0, pointer_pos_i = 0, plm_defect_i = 0;
   logic lcd_defect_i = 0, payload_blocked_o;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, data_i = 8'h00, reg_rdata_o, data_o;
   logic [2:0] external_path_overhead_input = 3'h0, soft_rdi_code_i = 3'h0;
   logic [7:0] mk = 8'h00, c0 = 8'h00, c2 = 8'h00, eq, acc, prv, b3_diff, e, m;
   int bad_count = 0, check_count = 0, pos = 0;
   path_alarm_b3_error_insert dut (.*);
   remote_path_model rpm (.clk_i, .nrst_i, .data_i(data_o), .b3_diff_o(b3_diff),
      .mark_i({spe_i, spe_start_i, parity_pos_i}));
   initial forever #12.5 clk_i = ~clk_i;
   // Expected remote defect code for the present select and defects
   function automatic logic [2:0] rdi();
      if (c0[4:3] == RDI_SRC_SOFTWARE) return soft_rdi_code_i;
      if (c0[4:3] != RDI_SRC_AUTO) return external_path_overhead_input;
      if (plm_defect_i && c2[PLM_ENABLE_BIT]) return c2[PLM_CODE_LSB +: 3];
      if (lcd_defect_i && c2[LCD_ENABLE_BIT]) return c2[LCD_CODE_LSB +: 3];
      return RDI_CLEAR_CODE;
   endfunction
   // Expected outbound byte, with AIS ahead of overhead insertion
   function automatic logic [7:0] obyte();
      if (c0[AIS_ENABLE_BIT] && (spe_i || pointer_pos_i)) return ALL_ONES;
      if (parity_pos_i) return prv ^ mk;
      if (status_pos_i) return {data_i[7:4], rdi(), data_i[0]};
      return data_i;
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic summarize();
      if (bad_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // Read data is registered, so it is looked at a cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      cmp(reg_rdata_o, x, "register read");
   endtask
   // Framing source: pointer byte, then SPE with start, parity, status
   always @(posedge clk_i) if (nrst_i) begin
      pos <= (pos + 1) % FR;
      data_i <= 8'($urandom);
      pointer_pos_i <= (pos == FR - 1);
      spe_i <= (pos != FR - 1);
      spe_start_i <= (pos == 0);
      parity_pos_i <= (pos == 1);
      status_pos_i <= (pos == 2);
      if (pos == 0) {plm_defect_i, lcd_defect_i, soft_rdi_code_i,
         external_path_overhead_input} <= 8'($urandom);
   end
   // Reference model; it sees inputs as the design samples them
   always @(posedge clk_i) if (!nrst_i) begin
      {mk, c0, c2, acc, prv} = 40'h0;
      eq = 8'h00;
   end else begin
      eq = obyte();
      if (spe_start_i) {prv, acc} = {acc, eq};
      else if (spe_i) acc = acc ^ eq;
      if (reg_wr_i && reg_addr_i == PARITY_MASK_OFFSET) mk = reg_wdata_i;
      if (reg_wr_i && reg_addr_i == TX_CONTROL0_OFFSET) c0 = reg_wdata_i & ~CONTROL0_RO_MASK;
      if (reg_wr_i && reg_addr_i == DEFECT_CTRL2_OFFSET) c2 = reg_wdata_i;
   end
   always @(negedge clk_i) if (nrst_i) cmp(data_o, eq, "byte");
   initial begin
      #1ms bad_count++;
      summarize();
   end
   initial begin
      void'($urandom(14));
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      wr(8'h00, 8'hFF);
      rd(PARITY_MASK_OFFSET, PARITY_MASK_RESET);
      rd(TX_CONTROL0_OFFSET, TX_CONTROL0_RESET);
      rd(DEFECT_CTRL2_OFFSET, DEFECT_CTRL2_RESET);
      rd(8'h00, 8'h00);
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
         wr(PARITY_MASK_OFFSET, m);
         repeat (4 * FR) @(posedge clk_i);
         @(negedge clk_i);
         cmp(b3_diff, m, "remote parity");
         rd(PARITY_MASK_OFFSET, m);
      end
      // Every source select, with random defect codes and enables
      for (int s = 0; s < 12; s++) begin
         e = 8'($urandom);
         wr(DEFECT_CTRL2_OFFSET, e);
         wr(TX_CONTROL0_OFFSET, 8'((s % 4) << 3));
         rd(DEFECT_CTRL2_OFFSET, e);
         repeat (2 * FR) @(posedge clk_i);
      end
      wr(TX_CONTROL0_OFFSET, 8'hFF);
      rd(TX_CONTROL0_OFFSET, 8'hFD);
      repeat (2 * FR) @(posedge clk_i);
      @(negedge clk_i);
      cmp({7'h0, payload_blocked_o}, 8'h01, "payload blocked");
      wr(TX_CONTROL0_OFFSET, 8'h00);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      cmp({7'h0, payload_blocked_o}, 8'h00, "payload released");
      repeat (3 * FR) @(posedge clk_i);
      summarize();
   end
endmodule
